// ==== src/ssc_pkg.sv ====
// constants and types for the standby output state control block
package ssc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 28;
    localparam int DEEP_W = 25;
    localparam int LIGHT_W = 22;
    localparam logic [11:0] ADDR_PWR = 12'h000;
    localparam logic [11:0] ADDR_OA = 12'h011;
    localparam logic [11:0] ADDR_SHOLD = 12'h014;
    localparam logic [11:0] ADDR_CFG = 12'h030;
    localparam logic [11:0] ADDR_STAT = 12'h031;
    localparam logic [11:0] ADDR_DEEP = 12'h0e2;
    localparam logic [11:0] ADDR_LIGHT = 12'h0f3;
    localparam int CFG_IDLE_BIT = 0;
    localparam int CFG_SLAVE_BIT = 1;
    localparam logic [1:0] PWR_RST = 2'h3;
    localparam logic OA_RST = 1'h0;
    localparam logic SHOLD_RST = 1'h0;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [24:0] DEEP_RST = 25'h0000000;
    localparam logic [21:0] LIGHT_RST = 22'h3fe000;
    // {reset_gate, hclk_4, hclk_3, hclk_2, hclk_1, hclk_last}
    localparam logic [5:0] HCLK_IDLE = 6'h14;
    typedef enum logic [1:0] {
        SSC_NORMAL = 2'b00,
        SSC_LIGHT1 = 2'b01,
        SSC_LIGHT2 = 2'b10,
        SSC_DEEP = 2'b11
    } ssc_pwr_t;
endpackage

// ==== src/ssc_standby_ctrl.sv ====
// power state and output override control for the ccd timing front end
// Behaviour
// - power state from bits 1:0, offset 0
// - 00 normal, 01/10/11 standby one/two/three
// - activate-low beats levels 1,2; level 3 beats it
// - level three stops oscillator, osc_out high
// - level three: core off, hclk hi-z, rest low
// - activate-low: fixed hclk, sync idle, data low
// - level two: core off, oscillator on, data_clock_out low
// - levels one, two: minimum hclk drive
// - slave mode: sync pins always hi-z
// - vdriver off: verticals mid, substrate low
// - level three verticals from deep hold levels
// - deep hold bit order from vertical_phase_1
// - levels one, two, activate-low use light levels
// - light hold bit order from vertical_phase_1
// - bias, shutter, strobe from deep hold levels
// - defaults: verticals low, gates high except three
// - activate takes effect at next sync rise
// - sync_hold forces activate-low states during sync
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module ssc_standby_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [ssc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ssc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ssc_pkg::DATA_W-1:0] rdata_o,
    // pins from outside
    input wire logic sync_pin_i,
    input wire logic vdriver_enable_i,
    // power control
    output logic afe_on_o,
    output logic afe_ref_on_o,
    output logic timing_core_on_o,
    output logic osc_enable_o,
    output logic osc_out_high_o,
    // horizontal and reset gate
    output logic hclk_force_o,
    output logic [5:0] hclk_level_o,
    output logic hclk_oe_o,
    output logic hdrive_min_o,
    // sync, data clock, data
    output logic sync_force_o,
    output logic [1:0] sync_level_o,
    output logic sync_oe_o,
    output logic data_clock_out_run_o,
    output logic data_force_low_o,
    // vertical, sensor gate, shutter
    output logic vert_force_o,
    output logic [ssc_pkg::DEEP_W-1:0] vert_level_o,
    output logic vdrv_mid_o,
    output logic substrate_pulse_low_rail_o
);
    import ssc_pkg::*;

    typedef struct packed {
        ssc_pwr_t ps;
        logic oa_wr;
        logic oa_pend;
        logic oa_eff;
        logic shold;
        logic [1:0] cfg;
        logic [DEEP_W-1:0] deep;
        logic [LIGHT_W-1:0] light;
        logic vdr_s1;
        logic vdr_s2;
        logic sy_s1;
        logic sy_s2;
        logic sy_prev;
        logic [DATA_W-1:0] rdata;
        logic afe_on;
        logic afe_ref;
        logic tc_on;
        logic osc_en;
        logic osc_hi;
        logic h_force;
        logic [5:0] h_lvl;
        logic h_oe;
        logic h_min;
        logic s_force;
        logic [1:0] s_lvl;
        logic s_oe;
        logic data_clock_out_run;
        logic d_low;
        logic v_force;
        logic [DEEP_W-1:0] v_lvl;
        logic v_mid;
        logic sub_low;
    } ssc_state_t;

    ssc_state_t state_reg;
    ssc_state_t state_next;

    function automatic logic is_light(input ssc_pwr_t p);
        return (p == SSC_LIGHT1) || (p == SSC_LIGHT2);
    endfunction

    logic sync_rise;
    logic forced_low;
    assign sync_rise = state_reg.sy_s2 && !state_reg.sy_prev;
    // a held sync operation is the low phase of the synchronised sync pin
    assign forced_low = !state_reg.oa_eff || (state_reg.shold && !state_reg.sy_s2);

    always_comb begin
        state_next = state_reg;
        state_next.vdr_s1 = vdriver_enable_i;
        state_next.vdr_s2 = state_reg.vdr_s1;
        state_next.sy_s1 = sync_pin_i;
        state_next.sy_s2 = state_reg.sy_s1;
        state_next.sy_prev = state_reg.sy_s2;
        // activation waits for a sync rise so outputs start on a clean frame
        if (sync_rise && state_reg.oa_pend) begin
            state_next.oa_eff = 1'b1;
            state_next.oa_pend = 1'b0;
        end
        if (wr_i) begin
            unique case (addr_i)
                ADDR_PWR: state_next.ps = ssc_pwr_t'(wdata_i[1:0]);
                ADDR_OA: begin
                    state_next.oa_wr = wdata_i[0];
                    // a sync rise in this same cycle has already made it effective; do not leave it pending too
                    state_next.oa_pend = wdata_i[0] && !state_next.oa_eff;
                    if (!wdata_i[0]) begin
                        state_next.oa_eff = 1'b0;
                    end
                end
                ADDR_SHOLD: state_next.shold = wdata_i[0];
                ADDR_CFG: state_next.cfg = wdata_i[1:0];
                ADDR_DEEP: state_next.deep = wdata_i[DEEP_W-1:0];
                ADDR_LIGHT: state_next.light = wdata_i[LIGHT_W-1:0];
                default: ;
            endcase
        end
        state_next.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_PWR: state_next.rdata = {26'h0, state_reg.ps};
                ADDR_OA: state_next.rdata = {27'h0, state_reg.oa_wr};
                ADDR_SHOLD: state_next.rdata = {27'h0, state_reg.shold};
                ADDR_CFG: state_next.rdata = {26'h0, state_reg.cfg};
                ADDR_STAT: state_next.rdata = {24'h0, state_reg.oa_eff, state_reg.oa_pend, state_reg.ps};
                ADDR_DEEP: state_next.rdata = {3'h0, state_reg.deep};
                ADDR_LIGHT: state_next.rdata = {6'h0, state_reg.light};
                default: state_next.rdata = '0;
            endcase
        end
        // power gating follows the power state alone; activate-low leaves it
        state_next.afe_on = (state_reg.ps == SSC_NORMAL);
        state_next.afe_ref = (state_reg.ps == SSC_LIGHT1);
        state_next.tc_on = (state_reg.ps == SSC_NORMAL) || (state_reg.ps == SSC_LIGHT1);
        state_next.osc_en = (state_reg.ps != SSC_DEEP);
        state_next.osc_hi = (state_reg.ps == SSC_DEEP);
        state_next.h_min = is_light(state_reg.ps);
        state_next.h_force = 1'b0;
        state_next.h_lvl = '0;
        state_next.h_oe = 1'b1;
        state_next.s_force = 1'b0;
        state_next.s_lvl = '0;
        state_next.data_clock_out_run = 1'b1;
        state_next.d_low = 1'b0;
        state_next.v_force = 1'b0;
        state_next.v_lvl = '0;
        if (state_reg.ps == SSC_DEEP) begin
            // deep sleep wins over the activate control
            state_next.h_force = 1'b1;
            state_next.h_oe = 1'b0;
            state_next.s_force = 1'b1;
            state_next.data_clock_out_run = 1'b0;
            state_next.d_low = 1'b1;
            state_next.v_force = 1'b1;
            state_next.v_lvl = state_reg.deep;
        end else if (forced_low || is_light(state_reg.ps)) begin
            state_next.h_force = 1'b1;
            state_next.h_lvl = HCLK_IDLE;
            state_next.d_low = 1'b1;
            state_next.v_force = 1'b1;
            state_next.v_lvl = {state_reg.deep[DEEP_W-1:LIGHT_W], state_reg.light};
            // activate-low takes priority over the two lighter levels
            if (forced_low || state_reg.ps == SSC_LIGHT2) begin
                state_next.s_force = 1'b1;
                state_next.s_lvl = {2{state_reg.cfg[CFG_IDLE_BIT]}};
            end
            state_next.data_clock_out_run = forced_low || state_reg.ps == SSC_LIGHT1;
        end
        state_next.s_oe = !state_reg.cfg[CFG_SLAVE_BIT];
        // the pin is the only say on the vertical driver rails
        state_next.v_mid = !state_reg.vdr_s2;
        state_next.sub_low = !state_reg.vdr_s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.ps <= ssc_pwr_t'(PWR_RST);
            state_reg.oa_wr <= OA_RST;
            state_reg.oa_eff <= OA_RST;
            state_reg.shold <= SHOLD_RST;
            state_reg.cfg <= CFG_RST;
            state_reg.deep <= DEEP_RST;
            state_reg.light <= LIGHT_RST;
            state_reg.h_oe <= 1'b0;
            state_reg.h_force <= 1'b1;
            state_reg.s_force <= 1'b1;
            state_reg.d_low <= 1'b1;
            state_reg.v_force <= 1'b1;
            state_reg.osc_hi <= 1'b1;
            state_reg.v_mid <= 1'b1;
            state_reg.sub_low <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign afe_on_o = state_reg.afe_on;
    assign afe_ref_on_o = state_reg.afe_ref;
    assign timing_core_on_o = state_reg.tc_on;
    assign osc_enable_o = state_reg.osc_en;
    assign osc_out_high_o = state_reg.osc_hi;
    assign hclk_force_o = state_reg.h_force;
    assign hclk_level_o = state_reg.h_lvl;
    assign hclk_oe_o = state_reg.h_oe;
    assign hdrive_min_o = state_reg.h_min;
    assign sync_force_o = state_reg.s_force;
    assign sync_level_o = state_reg.s_lvl;
    assign sync_oe_o = state_reg.s_oe;
    assign data_clock_out_run_o = state_reg.data_clock_out_run;
    assign data_force_low_o = state_reg.d_low;
    assign vert_force_o = state_reg.v_force;
    assign vert_level_o = state_reg.v_lvl;
    assign vdrv_mid_o = state_reg.v_mid;
    assign substrate_pulse_low_rail_o = state_reg.sub_low;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_pwr_write;
        wr_i && addr_i == ADDR_PWR |=> state_reg.ps == $past(wdata_i[1:0]);
    endproperty
    a_pwr_write: assert property (p_pwr_write) else $error("power state not applied after write");

    property p_deep_out;
        state_reg.ps == SSC_DEEP |=> !hclk_oe_o && sync_level_o == 2'h0 && !data_clock_out_run_o && data_force_low_o;
    endproperty
    a_deep_out: assert property (p_deep_out) else $error("deep sleep outputs wrong");

    property p_osc;
        state_reg.ps == SSC_DEEP |=> !osc_enable_o && osc_out_high_o && !timing_core_on_o && !afe_on_o;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator not stopped in deep sleep");

    property p_oa_low;
        state_reg.ps != SSC_DEEP && !state_reg.oa_eff |=> hclk_level_o == HCLK_IDLE && data_clock_out_run_o && sync_force_o;
    endproperty
    a_oa_low: assert property (p_oa_low) else $error("activate-low override wrong");

    property p_min_drive;
        is_light(state_reg.ps) |=> hdrive_min_o && hclk_oe_o;
    endproperty
    a_min_drive: assert property (p_min_drive) else $error("drive strength not minimum");

    property p_slave;
        state_reg.cfg[CFG_SLAVE_BIT] |=> !sync_oe_o;
    endproperty
    a_slave: assert property (p_slave) else $error("sync pins driven in slave mode");

    property p_vdr;
        !vdriver_enable_i ##1 !vdriver_enable_i[*2] |=> vdrv_mid_o && substrate_pulse_low_rail_o;
    endproperty
    a_vdr: assert property (p_vdr) else $error("vertical rails not parked");

    property p_deep_lvl;
        state_reg.ps == SSC_DEEP |=> vert_force_o && vert_level_o == $past(state_reg.deep);
    endproperty
    a_deep_lvl: assert property (p_deep_lvl) else $error("deep hold levels not driven");

    property p_light_lvl;
        is_light(state_reg.ps) |=> vert_level_o == {$past(state_reg.deep[24:22]), $past(state_reg.light)};
    endproperty
    a_light_lvl: assert property (p_light_lvl) else $error("light hold levels not driven");

    property p_oa_wait;
        state_reg.oa_pend && !sync_rise |=> !state_reg.oa_eff;
    endproperty
    a_oa_wait: assert property (p_oa_wait) else $error("activate before sync rise");

    property p_oa_go;
        state_reg.oa_pend && sync_rise && !wr_i |=> state_reg.oa_eff ##1 !data_force_low_o || state_reg.ps != SSC_NORMAL;
    endproperty
    a_oa_go: assert property (p_oa_go) else $error("activate missed sync rise");

    property p_lvl1;
        state_reg.ps == SSC_LIGHT1 |=> afe_ref_on_o && !afe_on_o && timing_core_on_o && osc_enable_o;
    endproperty
    a_lvl1: assert property (p_lvl1) else $error("level one power gating wrong");

    c_deep_exit: cover property (state_reg.ps == SSC_DEEP ##1 state_reg.ps == SSC_NORMAL);
    c_activate: cover property (state_reg.oa_pend ##[1:50] state_reg.oa_eff);
    c_hold: cover property (state_reg.oa_eff && state_reg.shold && !state_reg.sy_s2);
endmodule

// ==== verif/ssc_ccd_model.sv ====
// behavioural ccd and vertical driver stage facing the block's pins
`timescale 1ns/10ps
module ssc_ccd_model (
    // clock
    input wire logic clk_i,
    // bench controls
    input wire logic sync_lvl_i,
    input wire logic vdr_on_i,
    // block outputs
    input wire logic hclk_oe_i,
    input wire logic [5:0] hclk_level_i,
    // pins toward the block and the sensor
    output logic sync_pin_o,
    output logic vdriver_enable_o,
    output logic [5:0] hclk_wire_o
);
    logic [5:0] last_reg = 6'h00;

    always @(posedge clk_i) begin
        if (hclk_oe_i) begin
            last_reg <= hclk_level_i;
        end
    end

    // released lines float; show the inverse so a stale level never passes for a driven one
    assign hclk_wire_o = hclk_oe_i ? hclk_level_i : ~last_reg;
    assign sync_pin_o = sync_lvl_i;
    assign vdriver_enable_o = vdr_on_i;
endmodule

// ==== verif/tb_ssc_standby_ctrl.sv ====
// self-checking bench for the standby output state control block
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITC(c) begin for (wk = 0; wk < 20 && !(c); wk++) @(posedge clk_i) #1; \
    if (!(c)) begin n_errors++; end_sim(); end end
module tb_ssc_standby_ctrl;
    import ssc_pkg::*;
    localparam logic [7:0] PW_EXP [4] = '{8'hb5, 8'h77, 8'h17, 8'h08};
    // 500 us of oscillator settling at a 20 ns clock
    localparam int OSC_SETTLE_CYC = 25000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sync_lvl = 1'b0;
    logic vdr_on = 1'b1;
    logic [DATA_W-1:0] rdata_o;
    logic sync_pin_i, vdriver_enable_i;
    logic afe_on_o, afe_ref_on_o, timing_core_on_o, osc_enable_o, osc_out_high_o;
    logic hclk_force_o, hclk_oe_o, hdrive_min_o, sync_force_o, sync_oe_o;
    logic data_clock_out_run_o, data_force_low_o, vert_force_o, vdrv_mid_o, substrate_pulse_low_rail_o;
    logic [5:0] hclk_level_o, hclk_wire;
    logic [1:0] sync_level_o;
    logic [DEEP_W-1:0] vert_level_o;
    logic [7:0] pw;
    logic [24:0] dv;
    int n_errors = 0;
    int checked = 0;
    int wk, i;

    assign pw = {afe_on_o, afe_ref_on_o, timing_core_on_o, osc_enable_o, osc_out_high_o, hclk_oe_o,
        hdrive_min_o, data_clock_out_run_o};

    ssc_standby_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sync_pin_i(sync_pin_i), .vdriver_enable_i(vdriver_enable_i),
        .afe_on_o(afe_on_o), .afe_ref_on_o(afe_ref_on_o), .timing_core_on_o(timing_core_on_o),
        .osc_enable_o(osc_enable_o), .osc_out_high_o(osc_out_high_o), .hclk_force_o(hclk_force_o),
        .hclk_level_o(hclk_level_o), .hclk_oe_o(hclk_oe_o), .hdrive_min_o(hdrive_min_o),
        .sync_force_o(sync_force_o), .sync_level_o(sync_level_o), .sync_oe_o(sync_oe_o),
        .data_clock_out_run_o(data_clock_out_run_o), .data_force_low_o(data_force_low_o), .vert_force_o(vert_force_o),
        .vert_level_o(vert_level_o), .vdrv_mid_o(vdrv_mid_o), .substrate_pulse_low_rail_o(substrate_pulse_low_rail_o));

    ssc_ccd_model model_u (.clk_i(clk_i), .sync_lvl_i(sync_lvl), .vdr_on_i(vdr_on), .hclk_oe_i(hclk_oe_o),
        .hclk_level_i(hclk_level_o), .sync_pin_o(sync_pin_i), .vdriver_enable_o(vdriver_enable_i),
        .hclk_wire_o(hclk_wire));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, exp)
    endtask

    // outputs follow a write one edge after wr returns
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i) #1;
        `CHK(pw, 8'h08)
        `CHK(vert_level_o, 25'h0)
        rd(ADDR_PWR, 28'h3);
        rd(ADDR_DEEP, 28'h0);
        rd(ADDR_LIGHT, 28'h3fe000);
        rd(12'h0ff, 28'h0);
        wr(ADDR_PWR, 28'h0);
        #1;
        `CHK(afe_on_o, 1'b0)
        @(posedge clk_i) #1;
        `CHK(afe_on_o, 1'b1)
        for (i = 0; i < 4; i++) begin
            wr(ADDR_PWR, 28'(i));
            settle();
            `CHK(pw, PW_EXP[i])
            `CHK(vert_level_o, (i == 3) ? 25'h0 : 25'h3fe000)
            `CHK(data_force_low_o, 1'b1)
            if (i < 3) `CHK(hclk_wire, HCLK_IDLE)
        end
        wr(ADDR_CFG, 28'h1);
        settle();
        `CHK(sync_level_o, 2'b00)
        wr(ADDR_PWR, 28'h2);
        settle();
        `CHK({sync_force_o, sync_level_o}, 3'b111)
        dv = 25'h1abcdef;
        wr(ADDR_DEEP, 28'(dv));
        wr(ADDR_LIGHT, 28'h155555);
        settle();
        `CHK(vert_level_o, {dv[24:22], 22'h155555})
        wr(ADDR_CFG, 28'h3);
        settle();
        `CHK(sync_oe_o, 1'b0)
        wr(ADDR_CFG, 28'h1);
        wr(ADDR_PWR, 28'h3);
        settle();
        `CHK(vert_level_o, dv)
        wr(ADDR_PWR, 28'h0);
        // host lets the oscillator settle before bringing the core back into use
        repeat (OSC_SETTLE_CYC) @(posedge clk_i);
        #1;
        `CHK({osc_enable_o, osc_out_high_o, timing_core_on_o}, 3'b101)
        wr(ADDR_OA, 28'h1);
        repeat (6) @(posedge clk_i);
        #1;
        `CHK(vert_force_o, 1'b1)
        rd(ADDR_STAT, 28'h4);
        sync_lvl <= 1'b1;
        `WAITC(!vert_force_o)
        `CHK({hclk_force_o, sync_force_o, data_force_low_o}, 3'b000)
        rd(ADDR_STAT, 28'h8);
        wr(ADDR_SHOLD, 28'h1);
        sync_lvl <= 1'b0;
        `WAITC(vert_force_o)
        `CHK(hclk_level_o, HCLK_IDLE)
        sync_lvl <= 1'b1;
        wr(ADDR_SHOLD, 28'h0);
        `WAITC(!vert_force_o)
        wr(ADDR_PWR, 28'h1);
        settle();
        `CHK({sync_force_o, hdrive_min_o, data_force_low_o}, 3'b011)
        wr(ADDR_PWR, 28'h3);
        settle();
        `CHK({hclk_oe_o, osc_out_high_o}, 2'b01)
        `CHK(vert_level_o, dv)
        wr(ADDR_PWR, 28'h1);
        wr(ADDR_OA, 28'h0);
        settle();
        `CHK({sync_force_o, data_clock_out_run_o}, 2'b11)
        vdr_on <= 1'b0;
        `WAITC(vdrv_mid_o)
        `CHK(substrate_pulse_low_rail_o, 1'b1)
        vdr_on <= 1'b1;
        `WAITC(!vdrv_mid_o)
        `CHK(substrate_pulse_low_rail_o, 1'b0)
        end_sim();
    end
endmodule
